// ===== conv_pkg.sv
package conv_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam logic [3:0] ctrl_two_off = 4'h0;        // Control: clock-in-stop, freeze bits, continuous, channels
    localparam logic [3:0] seq_start_off = 4'h4;       // Write starts a sequence, read gives sequencer state
    localparam logic [3:0] result_off = 4'h8;          // Last stored result
    localparam logic [3:0] status_off = 4'hc;          // Not decoded, reads zero; sticky event bits are at 0x10
    localparam logic [3:0] int_clear_off = 4'h0;       // Clear register is at offset 0x14 below
    localparam logic [7:0] irq_status_off = 8'h10;     // Sticky status
    localparam logic [7:0] irq_clear_off = 8'h14;      // Write one to clear
    localparam logic [7:0] irq_enable_off = 8'h18;     // Enable mask
    localparam logic [7:0] compare_off = 8'h1c;        // Compare threshold

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int internal_conversion_clock_stop_bit = 0;
    localparam int frz_low_bit = 1;
    localparam int frz_high_bit = 2;
    localparam int cont_bit = 3;
    localparam int chan_lo_bit = 4;
    localparam logic [31:0] ctrl_reset = 32'h0000_0010;  // Channel field 1 (two channels when continuous), single, clock-in-stop off

    // Event bits in the interrupt status register
    localparam int ev_complete = 0;
    localparam int ev_seq_done = 1;
    localparam int ev_compare = 2;
    localparam int ev_aborted = 3;
    localparam int ev_width = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int clk_mhz = 25;
    localparam int stop_recovery_time_ns = 1000;       // Chosen default recovery period
    localparam int stop_recovery_cycles = (stop_recovery_time_ns * clk_mhz + 999) / 1000;
    localparam int conv_cycles = 14;                   // Cycles per conversion on the bus-derived clock

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        seq_idle = 4'h1,
        seq_conv = 4'h2,
        seq_held = 4'h4,
        seq_recover = 4'h8
    } seq_state_t;

    // System mode inputs travel together
    typedef struct packed
    {
        logic stop;
        logic wait_mode;
        logic freeze;
    } sys_mode_t;

    // Avalon-MM request
    typedef struct packed
    {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } bus_req_t;

endpackage

// ===== clk_switch.sv
`timescale 1ns/1ps

// Glitch-free choice between bus-derived and internal conversion ticks.
// Both sources are tick enables in the one clock domain; a change of source
// waits until neither source is mid-pulse so no partial tick is passed on.
module clk_switch
(
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_tick,
    input wire logic int_tick,
    input wire logic use_internal,
    output logic tick,
    output logic on_internal
)
;
    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    // Switch only in a cycle where both ticks are quiet
    always_ff @(posedge clk)
    begin
        if (rst)
            on_internal <= 1'b0;
        else if (!bus_tick && !int_tick)
            on_internal <= use_internal;
    end

    // Registered tick from the currently owned source
    always_ff @(posedge clk)
    begin
        if (rst)
            tick <= 1'b0;
        else
            tick <= on_internal ? int_tick : bus_tick;
    end
endmodule

// ===== conv_ctrl.sv
`timescale 1ns/1ps

// What this block does
// - Single or continuous, one or several channels
// - Stop entry aborts sequence when clock-in-stop off
// - Aborted sequence restarts after stop exit
// - Restart acts like start write, clears flags
// - Clock-in-stop on keeps converting on internal clock
// - Transition-spanning conversion stores no result
// - Transition-spanning conversion sets no flag, no compare
// - Recovery period before returning to bus clock
// - Wait mode behaves exactly like run
// - Freeze: continue, finish current, or stop
module conv_ctrl
#(
    parameter int chan_count = 16,
    parameter int data_width = 12,
    parameter int bus_div = 2,
    parameter int int_div = 3
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire conv_pkg::sys_mode_t sys_mode,
    input wire logic [data_width-1:0] sample_in,
    output logic [3:0] sample_channel,
    output logic irq,
    output logic recovering
)
;
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    conv_pkg::seq_state_t state_reg;             // Sequencer state
    logic [31:0] ctrl_reg;                       // Control register
    logic [31:0] compare_reg;                    // Compare threshold
    logic [data_width-1:0] result_reg;           // Last stored result
    logic [conv_pkg::ev_width-1:0] irq_status_reg;  // Sticky events
    logic [conv_pkg::ev_width-1:0] irq_enable_reg;  // Event mask
    logic [conv_pkg::ev_width-1:0] ev_set;       // Events this cycle
    logic [chan_count-1:0] ccf_reg;              // Per-channel complete flags
    logic [4:0] conv_cnt_reg;                    // Ticks inside a conversion
    logic [3:0] chan_reg;                        // Channel being converted
    logic [4:0] seq_left_reg;                    // Conversions left in sequence
    logic [15:0] recov_cnt_reg;                  // Recovery countdown
    logic pending_restart_reg;                   // Sequence aborted by stop
    logic spanned_reg;                           // Run/stop edge during conversion
    logic stop_d_reg;                            // Previous stop level
    logic [3:0] bus_div_reg;                     // Bus tick divider
    logic [3:0] int_div_reg;                     // Internal tick divider
    logic bus_tick;
    logic int_tick;
    logic tick;
    logic on_internal;
    logic start_wr;
    logic stop_rise;
    logic stop_fall;
    logic frozen_hold;
    logic conv_done;
    logic [4:0] seq_len;

    // Control fields
    wire internal_conversion_clock_stop = ctrl_reg[conv_pkg::internal_conversion_clock_stop_bit];
    wire frz_low = ctrl_reg[conv_pkg::frz_low_bit];
    wire frz_high = ctrl_reg[conv_pkg::frz_high_bit];
    wire cont_mode = ctrl_reg[conv_pkg::cont_bit];

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Waitrequest idles high and drops for one cycle once a request is seen;
    // a registered waitrequest cannot rise in the first cycle of a read, so every
    // access, write included, costs one wait cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge clk)
    begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (avs_address == {4'h0, conv_pkg::ctrl_two_off})
            avs_readdata <= ctrl_reg;
        else if (avs_address == {4'h0, conv_pkg::seq_start_off})
            avs_readdata <= 32'({ccf_reg, state_reg, seq_left_reg});
        else if (avs_address == {4'h0, conv_pkg::result_off})
            avs_readdata <= 32'(result_reg);
        else if (avs_address == conv_pkg::irq_status_off)
            avs_readdata <= 32'(irq_status_reg);
        else if (avs_address == conv_pkg::irq_enable_off)
            avs_readdata <= 32'(irq_enable_reg);
        else if (avs_address == conv_pkg::compare_off)
            avs_readdata <= compare_reg;
        else
            avs_readdata <= 32'h0000_0000;
    end

    // Writes take effect only at the edge where the request is accepted
    wire wr_ok = avs_write && !avs_waitrequest;
    assign start_wr = wr_ok && avs_address == {4'h0, conv_pkg::seq_start_off};

    // Control register
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl_reg <= conv_pkg::ctrl_reset;
        else if (wr_ok && avs_address == {4'h0, conv_pkg::ctrl_two_off})
            ctrl_reg <= avs_writedata;
    end

    // Compare threshold
    always_ff @(posedge clk)
    begin
        if (rst)
            compare_reg <= 32'h0000_0000;
        else if (wr_ok && avs_address == conv_pkg::compare_off)
            compare_reg <= avs_writedata;
    end

    // Interrupt enable
    always_ff @(posedge clk)
    begin
        if (rst)
            irq_enable_reg <= '0;
        else if (wr_ok && avs_address == conv_pkg::irq_enable_off)
            irq_enable_reg <= avs_writedata[conv_pkg::ev_width-1:0];
    end

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            irq_status_reg <= '0;
        else if (wr_ok && avs_address == conv_pkg::irq_clear_off)
            irq_status_reg <= (irq_status_reg & ~avs_writedata[conv_pkg::ev_width-1:0]) | ev_set;
        else
            irq_status_reg <= irq_status_reg | ev_set;
    end

    // Level interrupt
    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |((irq_status_reg | ev_set) & irq_enable_reg);
    end

    // ------------------------------------------------------------
    // Conversion tick sources
    // ------------------------------------------------------------
    // Bus-derived and internal ticks; the internal one runs regardless of stop
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus_div_reg <= 4'h0;
            int_div_reg <= 4'h0;
        end
        else
        begin
            bus_div_reg <= (bus_div_reg == 4'(bus_div - 1)) ? 4'h0 : bus_div_reg + 4'h1;
            int_div_reg <= (int_div_reg == 4'(int_div - 1)) ? 4'h0 : int_div_reg + 4'h1;
        end
    end
    // Bus clock is gated while the system sits in stop
    assign bus_tick = bus_div_reg == 4'h0 && !sys_mode.stop;
    assign int_tick = int_div_reg == 4'h0;

    clk_switch u_clk_switch
    (
        .clk(clk),
        .rst(rst),
        .bus_tick(bus_tick),
        .int_tick(int_tick),
        .use_internal(internal_conversion_clock_stop && (sys_mode.stop || state_reg == conv_pkg::seq_recover)),
        .tick(tick),
        .on_internal(on_internal)
    );

    // ------------------------------------------------------------
    // Mode edges and freeze
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            stop_d_reg <= 1'b0;
        else
            stop_d_reg <= sys_mode.stop;
    end
    assign stop_rise = sys_mode.stop && !stop_d_reg;
    assign stop_fall = !sys_mode.stop && stop_d_reg;

    // Freeze: 00 continue, 01 reserved as continue, 10 finish current, 11 stop now
    assign frozen_hold = sys_mode.freeze && frz_high && (frz_low || conv_cnt_reg == 5'd0);
    // Wait mode deliberately has no term here: same as run

    assign seq_len = cont_mode ? 5'(ctrl_reg[conv_pkg::chan_lo_bit +: 4]) + 5'd1 : 5'd1;
    assign conv_done = state_reg == conv_pkg::seq_conv && tick && !frozen_hold
                       && conv_cnt_reg == 5'(conv_pkg::conv_cycles - 1);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= conv_pkg::seq_idle;
            conv_cnt_reg <= 5'd0;
            chan_reg <= 4'h0;
            seq_left_reg <= 5'd0;
            pending_restart_reg <= 1'b0;
            recov_cnt_reg <= 16'h0000;
        end
        else if (stop_rise && !internal_conversion_clock_stop && state_reg == conv_pkg::seq_conv)
        begin
            state_reg <= conv_pkg::seq_held;
            conv_cnt_reg <= 5'd0;
            pending_restart_reg <= 1'b1;
        end
        else if (start_wr || (state_reg == conv_pkg::seq_held && !sys_mode.stop && pending_restart_reg))
        begin
            state_reg <= conv_pkg::seq_conv;
            conv_cnt_reg <= 5'd0;
            chan_reg <= 4'h0;
            seq_left_reg <= seq_len;
            pending_restart_reg <= 1'b0;
        end
        else if (stop_fall && internal_conversion_clock_stop && on_internal)
        begin
            // Hold off bus-clock use until the internal clock has been released
            state_reg <= conv_pkg::seq_recover;
            recov_cnt_reg <= 16'(conv_pkg::stop_recovery_cycles);
            conv_cnt_reg <= 5'd0;
            pending_restart_reg <= state_reg == conv_pkg::seq_conv;
        end
        else if (state_reg == conv_pkg::seq_recover)
        begin
            if (recov_cnt_reg <= 16'h0001)
                state_reg <= pending_restart_reg ? conv_pkg::seq_conv : conv_pkg::seq_idle;
            recov_cnt_reg <= recov_cnt_reg - 16'h0001;
            pending_restart_reg <= 1'b0;
        end
        else if (state_reg == conv_pkg::seq_conv && tick && !frozen_hold)
        begin
            // Keeps running through stop on the internal clock
            conv_cnt_reg <= conv_done ? 5'd0 : conv_cnt_reg + 5'd1;
            if (conv_done)
            begin
                chan_reg <= chan_reg + 4'h1;
                if (seq_left_reg == 5'd1)
                begin
                    seq_left_reg <= seq_len;
                    chan_reg <= 4'h0;
                    if (!cont_mode)
                        state_reg <= conv_pkg::seq_idle;
                end
                else
                    seq_left_reg <= seq_left_reg - 5'd1;
            end
        end
    end

    // A run/stop edge during a conversion taints that conversion
    always_ff @(posedge clk)
    begin
        if (rst)
            spanned_reg <= 1'b0;
        else if (conv_done || start_wr || state_reg == conv_pkg::seq_held)
            spanned_reg <= 1'b0;  // An aborted conversion must not taint the restart
        else if ((stop_rise || stop_fall) && state_reg == conv_pkg::seq_conv)
            spanned_reg <= 1'b1;
    end

    // ------------------------------------------------------------
    // Results and flags
    // ------------------------------------------------------------
    wire good_done = conv_done && !spanned_reg && !(stop_rise || stop_fall);
    wire restart = state_reg == conv_pkg::seq_held && !sys_mode.stop && pending_restart_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
            result_reg <= '0;
        else if (good_done)
            result_reg <= sample_in;
    end

    // Complete flags: cleared on any start, hardware or software
    always_ff @(posedge clk)
    begin
        if (rst)
            ccf_reg <= '0;
        else if (start_wr || restart)
            ccf_reg <= '0;
        else if (good_done)
            ccf_reg[chan_reg] <= 1'b1;
    end

    // Events feeding the sticky status
    always_comb
    begin
        ev_set = '0;
        ev_set[conv_pkg::ev_complete] = good_done;
        ev_set[conv_pkg::ev_seq_done] = good_done && seq_left_reg == 5'd1;
        ev_set[conv_pkg::ev_compare] = good_done && 32'(sample_in) >= compare_reg;
        ev_set[conv_pkg::ev_aborted] = stop_rise && !internal_conversion_clock_stop && state_reg == conv_pkg::seq_conv;
    end

    // Output registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sample_channel <= 4'h0;
            recovering <= 1'b0;
        end
        else
        begin
            sample_channel <= chan_reg;
            recovering <= state_reg == conv_pkg::seq_recover;
        end
    end
endmodule

// ===== conv_ctrl_checker.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Port checks for the converter control block
// ------------------------------------------------------------
module conv_ctrl_checker
#(
    parameter int data_width = 12
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire conv_pkg::sys_mode_t sys_mode,
    input wire logic [data_width-1:0] sample_in,
    input wire logic [3:0] sample_channel,
    input wire logic irq,
    input wire logic recovering
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    logic [7:0] rec_cnt_reg; // Cycles spent so far in the current recovery period

    // Counts recovery cycles; eight bits leave headroom over the chosen period
    always_ff @(posedge clk)
    begin
        if (rst || !recovering)
            rec_cnt_reg <= 8'h00;
        else
            rec_cnt_reg <= rec_cnt_reg + 8'h01;
    end

    a_read_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read kept waiting beyond one cycle");
    a_write_one_wait: assert property (avs_write && avs_waitrequest |=> !avs_waitrequest)
        else $error("write kept waiting beyond one cycle");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 8'h1c |-> avs_readdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq && !recovering && avs_readdata == 32'h0)
        else $error("outputs not quiet during reset");
    a_irq_masked: assert property (avs_write && !avs_waitrequest && avs_address == conv_pkg::irq_enable_off
        && avs_writedata[3:0] == 4'h0 |-> ##[1:2] !irq)
        else $error("interrupt stayed up after all enables cleared");
    a_recover_len: assert property ($fell(recovering) |-> rec_cnt_reg == conv_pkg::stop_recovery_cycles)
        else $error("recovery period of wrong length");
    a_recover_bound: assert property (recovering |-> rec_cnt_reg < conv_pkg::stop_recovery_cycles)
        else $error("recovery period overran");
    a_recover_exit: assert property ($rose(recovering) |-> !sys_mode.stop)
        else $error("recovery began while still in stop");

    // Main scenarios reached
    c_recovery: cover property ($rose(recovering));
    c_irq: cover property ($rose(irq));
    c_stop: cover property ($rose(sys_mode.stop));
endmodule

bind conv_ctrl conv_ctrl_checker #(.data_width(data_width)) i_conv_ctrl_checker (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sys_mode(sys_mode),
    .sample_in(sample_in), .sample_channel(sample_channel), .irq(irq), .recovering(recovering));

// ===== sample_source.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Analog front end stand-in
// ------------------------------------------------------------
module sample_source
#(
    parameter int data_width = 12
)
(
    input wire logic [3:0] sample_channel,
    input wire logic [7:0] level,
    output logic [data_width-1:0] sample_in
);
    // Each channel reads as its own number above a shared level, so a stored
    // result tells which channel it came from
    assign sample_in = data_width'({sample_channel, level});
endmodule

// ===== conv_ctrl_test.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Self-checking bench for the converter control block
// ------------------------------------------------------------
module conv_ctrl_test;
    localparam logic [7:0] ctrl_a = 8'(conv_pkg::ctrl_two_off);
    localparam logic [7:0] start_a = 8'(conv_pkg::seq_start_off);
    localparam logic [7:0] result_a = 8'(conv_pkg::result_off);
    localparam logic [1:0] frz_tab [3] = '{2'b00, 2'b10, 2'b11}; // Continue, finish, stop
    logic clk = 1'b0;
    logic rst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    conv_pkg::sys_mode_t sys_mode;
    logic [11:0] sample_in;
    logic [3:0] sample_channel;
    logic irq;
    logic recovering;
    logic [7:0] level; // Shared sample level driven into the front end
    logic [7:0] lvl; // Level chosen for the current scenario
    logic [32:0] rd_q [$]; // Expected read data; bit 32 says whether it is checked
    logic [32:0] note;
    int rec_q [$]; // Expected recovery lengths
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    int rec_len = 0;
    int seed;
    logic [31:0] d;

    always #20 clk = ~clk;

    conv_ctrl i_conv_ctrl (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sys_mode(sys_mode), .sample_in(sample_in),
        .sample_channel(sample_channel), .irq(irq), .recovering(recovering));
    sample_source i_sample_source (.sample_channel(sample_channel), .level(level), .sample_in(sample_in));

    // ------------------------------------------------------------
    // Comparison and closing
    // ------------------------------------------------------------
    task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask

    task automatic check_len(input int exp, input int got);
        compares++;
        if (got != exp)
        begin
            n_fail++;
            $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d, n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Avalon master; an idle cycle follows each transfer so no signal is set twice at one edge
    // ------------------------------------------------------------
    task automatic bus_write(input logic [7:0] a, input logic [31:0] v);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_read(input logic [7:0] a, input logic chk, input logic [31:0] exp, output logic [31:0] v);
        rd_q.push_back({chk, exp});
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic expect_read(input logic [7:0] a, input logic [31:0] exp);
        bus_read(a, 1'b1, exp, d);
    endtask

    // Polls status until the sequence-done event shows
    task automatic wait_done;
        do bus_read(conv_pkg::irq_status_off, 1'b0, 32'h0, d); while (d[conv_pkg::ev_seq_done] !== 1'b1);
    endtask

    // Clears every event, sets enables and threshold, then starts a sequence
    task automatic start_seq(input logic [31:0] ctrl, input logic [31:0] en, input logic [31:0] thr);
        bus_write(conv_pkg::irq_clear_off, 32'h0000_000f);
        bus_write(conv_pkg::irq_enable_off, en);
        bus_write(conv_pkg::compare_off, thr);
        bus_write(ctrl_a, ctrl);
        bus_write(start_a, 32'h0);
    endtask

    // ------------------------------------------------------------
    // Monitor: read data against the oldest note, recovery length, timeout
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0)
        begin
            note = rd_q.pop_front();
            if (note[32])
                check_word(note[31:0], avs_readdata);
        end
        if (recovering === 1'b1)
            rec_len++;
        else if (rec_len > 0)
        begin
            check_len(rec_q.size() > 0 ? rec_q.pop_front() : 0, rec_len);
            rec_len = 0;
        end
        // A hang counts as a failure
        if (cycles == 20000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 81656;
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        sys_mode = '0;
        level = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, then an unmapped place that ignores writes
        expect_read(ctrl_a, conv_pkg::ctrl_reset);
        expect_read(conv_pkg::irq_status_off, 32'h0);
        bus_write(8'h20, 32'hffff_ffff);
        expect_read(8'h20, 32'h0);
        // Single conversion in wait mode, threshold equal to the sample
        lvl = 8'($random(seed));
        level <= lvl;
        sys_mode.wait_mode <= 1'b1;
        start_seq(32'h0, 32'hf, {24'h0, lvl});
        wait_done();
        expect_read(result_a, {24'h0, lvl});
        expect_read(conv_pkg::irq_status_off, 32'h7);
        check_word(32'h1, {31'h0, irq});
        // Masked run with threshold one above the sample
        start_seq(32'h0, 32'h0, {24'h0, lvl} + 32'h1);
        wait_done();
        expect_read(conv_pkg::irq_status_off, 32'h3);
        check_word(32'h0, {31'h0, irq});
        // Stop entry mid-conversion with the internal clock off: abort, then restart
        start_seq(32'h0, 32'hf, {24'h0, lvl});
        repeat (4) @(posedge clk);
        sys_mode.stop <= 1'b1;
        repeat (40) @(posedge clk);
        sys_mode.stop <= 1'b0;
        wait_done();
        expect_read(conv_pkg::irq_status_off, 32'hf);
        expect_read(result_a, {24'h0, lvl});
        // Each freeze behaviour, frozen mid-conversion
        for (int m = 0; m < 3; m++)
        begin
            start_seq({29'h0, frz_tab[m], 1'b0}, 32'hf, {24'h0, lvl});
            repeat (4) @(posedge clk);
            sys_mode.freeze <= 1'b1;
            repeat (100) @(posedge clk);
            expect_read(conv_pkg::irq_status_off, (m == 2) ? 32'h0 : 32'h7);
            sys_mode.freeze <= 1'b0;
            wait_done();
        end
        // Continuous over two channels; the sequence ends on the second one
        start_seq(32'h18, 32'hf, 32'h0);
        wait_done();
        expect_read(result_a, {20'h0, 4'h1, lvl});
        bus_write(ctrl_a, 32'h0);
        repeat (100) @(posedge clk);
        // Whole sequence inside stop on the internal clock, then recovery
        lvl = 8'($random(seed));
        level <= lvl;
        bus_write(ctrl_a, 32'h1);
        sys_mode.stop <= 1'b1;
        repeat (4) @(posedge clk);
        start_seq(32'h1, 32'hf, 32'h0);
        repeat (150) @(posedge clk);
        expect_read(conv_pkg::irq_status_off, 32'h7);
        expect_read(result_a, {24'h0, lvl});
        rec_q.push_back(conv_pkg::stop_recovery_cycles);
        sys_mode.stop <= 1'b0;
        // No register access until the recovery period is over
        while (rec_q.size() != 0) @(posedge clk);
        expect_read(ctrl_a, 32'h1);
        report_and_stop();
    end
endmodule
